// file: rtl/dsp_seq_regs.vh
/*
 Constants of the address generator, sequencer, cache and timer block.
 Included by the design file; it holds definitions only.
*/
// Notes on behaviour
// - First generator outputs 32-bit data memory addresses.
// - Second generator outputs 24-bit program memory data addresses.
// - Each generator holds eight pointers, modifiers, lengths and bases.
// - Indirect pointer updated by chosen modifier, before or after access.
// - Pointer wraps modulo its own buffer length register.
// - Per-pointer base marks circular buffer start anywhere.
// - Both generators may output an address in one cycle.
// - Every generator register has a selectable shadow copy.
// - Hardware loop counter and stack repeat loops with no overhead.
// - Cache is two-way set-associative holding 32 instruction words.
// - Cache stores only fetches colliding with program memory data access.
// - On hit during colliding access, instruction comes from cache.
// - After reset primary sets are active, shadow sets inactive.
// - Mode bits select shadow sets: data regs, generators, multiplier result.
// - Upper and lower data register halves have independent select bits.
// - Upper and lower four generator groups have independent select bits.
// - Four external, nine internal and eight software interrupt sources.
// - External or timer service pushes status and mode, five levels.
// - Arithmetic exceptions raise internal interrupts.
// - Enabled timer decrements 32-bit count every cycle.
// - Count at zero raises timer interrupt and expiry output.
// - At zero count reloads from period and keeps counting.
`ifndef DSP_SEQ_REGS_VH
`define DSP_SEQ_REGS_VH
// First mode control register fields
`define MODE_W 8
`define MODE_RST 8'h00
`define MODE_DREG_LO 0
`define MODE_DREG_HI 1
`define MODE_DAG0_LO 2
`define MODE_DAG0_HI 3
`define MODE_DAG1_LO 4
`define MODE_DAG1_HI 5
`define MODE_MR_ALT 6
`define MODE_IRQ_EN 7
// Generator register kinds on the write port
`define KIND_PTR 2'h0
`define KIND_MOD 2'h1
`define KIND_LEN 2'h2
`define KIND_BASE 2'h3
// Interrupt source layout
`define IRQ_N 21
`define IRQ_TIMER 4
`define IRQ_ARITH 5
`define IRQ_SOFT 13
`define STACK_DEPTH 5
`define LOOP_DEPTH 4
`define PC_RST 24'h000000
`endif

// file: rtl/dsp_address_sequencer_timer.v
/*
 Address generators, program sequencer with loop hardware and selective
 cache, shadow set selection, interrupt latching with status stacking,
 and interval timer. Assumes external memories answer in the same cycle
 and instruction decode lives outside.
*/
`timescale 1ns/1ps
`include "dsp_seq_regs.vh"
module dsp_address_sequencer_timer (
    input wire clock,
    input wire rst,
    input wire [1:0] dag_wr_en,
    input wire [1:0] dag_wr_kind,
    input wire [2:0] dag_wr_idx,
    input wire [31:0] dag_wr_data,
    input wire [1:0] acc_en,
    input wire [5:0] acc_ptr,
    input wire [5:0] acc_mod,
    input wire [1:0] acc_pre,
    output wire [31:0] data_space_addr_gen,
    output wire [23:0] program_space_addr_gen,
    output reg [1:0] addr_valid,
    input wire mode_wr,
    input wire [7:0] mode_wr_data,
    output wire [7:0] first_mode_control_reg,
    output wire dreg_lo_alt,
    output wire dreg_hi_alt,
    output wire mr_alt,
    input wire [31:0] astat_in,
    output reg [31:0] astat_restore,
    output reg astat_restore_valid,
    input wire [3:0] ext_irq,
    input wire [7:0] arith_exc,
    input wire [7:0] soft_irq,
    input wire irq_ack,
    input wire [4:0] irq_ack_idx,
    input wire irq_ret,
    output wire [20:0] irq_pending,
    output wire irq_request,
    output reg stack_overflow,
    input wire run,
    input wire jump,
    input wire [23:0] jump_addr,
    input wire loop_push,
    input wire [23:0] loop_end_addr,
    input wire [31:0] loop_count,
    output wire [23:0] fetch_addr,
    input wire [47:0] pm_instr,
    input wire pm_data_access,
    output reg [47:0] instr_out,
    output reg instr_valid,
    output wire fetch_stall,
    input wire timer_en,
    input wire timer_count_wr,
    input wire timer_period_wr,
    input wire [31:0] timer_wr_data,
    output wire [31:0] timer_count,
    output reg timer_expiry_out
);

    // ==========================================================
    // Shadow set selection
    // ==========================================================
    reg [7:0] mode_reg;
    reg [7:0] mode_next;
    reg [63:0] addr_reg;
    wire [63:0] addr_next;

    assign first_mode_control_reg = mode_reg;
    assign dreg_lo_alt = mode_reg[`MODE_DREG_LO];
    assign dreg_hi_alt = mode_reg[`MODE_DREG_HI];
    assign mr_alt = mode_reg[`MODE_MR_ALT];
    assign data_space_addr_gen = addr_reg[31:0];
    assign program_space_addr_gen = addr_reg[55:32];

    // ==========================================================
    // Address generators, one generate copy per generator
    // ==========================================================
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : dag
            // Index is set*8+register; shadow copies sit in 8..15
            reg [31:0] ptr_mem [0:15];
            reg [31:0] mod_mem [0:15];
            reg [31:0] len_mem [0:15];
            reg [31:0] base_mem [0:15];
            wire [2:0] pi;
            wire [2:0] mi;
            wire [2:0] wi;
            wire psel;
            wire msel;
            wire wsel;
            wire [3:0] pa;
            wire [3:0] ma;
            wire [3:0] wa;
            wire [31:0] p;
            wire [31:0] b;
            wire [31:0] l;
            wire [31:0] sum;
            wire [31:0] top;
            reg [31:0] wrapped;
            integer k;

            assign pi = acc_ptr[g*3 +: 3];
            assign mi = acc_mod[g*3 +: 3];
            assign wi = dag_wr_idx;
            // Lower four and upper four groups pick their set apart
            assign psel = pi[2] ? mode_reg[3+g*2] : mode_reg[2+g*2];
            assign msel = mi[2] ? mode_reg[3+g*2] : mode_reg[2+g*2];
            assign wsel = wi[2] ? mode_reg[3+g*2] : mode_reg[2+g*2];
            assign pa = {psel, pi};
            assign ma = {msel, mi};
            assign wa = {wsel, wi};
            assign p = ptr_mem[pa];
            assign b = base_mem[pa];
            assign l = len_mem[pa];
            assign sum = p + mod_mem[ma];
            assign top = b + l;

            // Circular wrap against the pointer's own base and length
            always @* begin
                wrapped = sum;
                if (l != 32'h0) begin
                    if (sum >= top) begin
                        wrapped = sum - l;
                    end else if (sum < b) begin
                        wrapped = sum + l;
                    end
                end
                if (g == 1) begin
                    wrapped = {8'h00, wrapped[23:0]};
                end
            end

            // Pre-modify drives the new value, post-modify the old one
            assign addr_next[g*32 +: 32] = acc_pre[g] ? wrapped : p;

            // A register write in the same cycle as an update wins
            always @(posedge clock) begin
                if (rst) begin
                    for (k = 0; k < 16; k = k + 1) begin
                        ptr_mem[k] <= 32'h0;
                        mod_mem[k] <= 32'h0;
                        len_mem[k] <= 32'h0;
                        base_mem[k] <= 32'h0;
                    end
                end else begin
                    if (acc_en[g]) begin
                        ptr_mem[pa] <= wrapped;
                    end
                    if (dag_wr_en[g]) begin
                        case (dag_wr_kind)
                            `KIND_PTR: ptr_mem[wa] <= dag_wr_data;
                            `KIND_MOD: mod_mem[wa] <= dag_wr_data;
                            `KIND_LEN: len_mem[wa] <= dag_wr_data;
                            default: base_mem[wa] <= dag_wr_data;
                        endcase
                    end
                end
            end
        end
    endgenerate

    // Both generators register their address together
    always @(posedge clock) begin
        if (rst) begin
            addr_reg <= 64'h0;
            addr_valid <= 2'h0;
        end else begin
            addr_reg <= addr_next;
            addr_valid <= acc_en;
        end
    end

    // ==========================================================
    // Interrupt latching
    // ==========================================================
    reg [3:0] ext_meta_reg;
    reg [3:0] ext_sync_reg;
    reg [3:0] ext_prev_reg;
    reg [20:0] pend_reg;
    wire [20:0] raise;
    wire [20:0] clr;
    wire timer_zero;
    wire stacked_src;

    // External lines are asynchronous, edges taken after the pair
    always @(posedge clock) begin
        if (rst) begin
            ext_meta_reg <= 4'h0;
            ext_sync_reg <= 4'h0;
            ext_prev_reg <= 4'h0;
        end else begin
            ext_meta_reg <= ext_irq;
            ext_sync_reg <= ext_meta_reg;
            ext_prev_reg <= ext_sync_reg;
        end
    end

    assign raise = {soft_irq, arith_exc, timer_zero, ext_sync_reg & ~ext_prev_reg};
    assign clr = (irq_ack ? (21'h000001 << irq_ack_idx) : 21'h0);
    assign irq_pending = pend_reg;
    assign irq_request = mode_reg[`MODE_IRQ_EN] && (pend_reg != 21'h0);
    assign stacked_src = irq_ack && (irq_ack_idx <= 5'd4);

    // A new event beats an acknowledge landing in the same cycle
    always @(posedge clock) begin
        if (rst) begin
            pend_reg <= 21'h0;
        end else begin
            pend_reg <= (pend_reg & ~clr) | raise;
        end
    end

    // ==========================================================
    // Status stack, five levels for external and timer service
    // ==========================================================
    reg [39:0] stk_mem [0:4];
    reg [2:0] sp_reg;
    integer s;

    always @* begin
        mode_next = mode_reg;
        if (irq_ret && sp_reg != 3'h0) begin
            mode_next = stk_mem[sp_reg - 3'h1][39:32];
        end
        if (mode_wr) begin
            mode_next = mode_wr_data;
        end
    end

    // Overflow drops the push; software sees the sticky flag
    always @(posedge clock) begin
        if (rst) begin
            mode_reg <= `MODE_RST;
            sp_reg <= 3'h0;
            stack_overflow <= 1'b0;
            astat_restore <= 32'h0;
            astat_restore_valid <= 1'b0;
            for (s = 0; s < `STACK_DEPTH; s = s + 1) begin
                stk_mem[s] <= 40'h0;
            end
        end else begin
            mode_reg <= mode_next;
            astat_restore_valid <= 1'b0;
            if (stacked_src) begin
                if (sp_reg < 3'd5) begin
                    stk_mem[sp_reg] <= {mode_reg, astat_in};
                    sp_reg <= sp_reg + 3'h1;
                end else begin
                    stack_overflow <= 1'b1;
                end
            end else if (irq_ret && sp_reg != 3'h0) begin
                astat_restore <= stk_mem[sp_reg - 3'h1][31:0];
                astat_restore_valid <= 1'b1;
                sp_reg <= sp_reg - 3'h1;
            end
        end
    end

    // ==========================================================
    // Sequencer with loop stack
    // ==========================================================
    reg [23:0] pc_reg;
    reg [23:0] pc_next;
    reg [23:0] lend_mem [0:3];
    reg [23:0] lstart_mem [0:3];
    reg [31:0] lcnt_mem [0:3];
    reg [2:0] lsp_reg;
    wire [1:0] ltop;
    wire at_end;
    integer q;

    assign ltop = lsp_reg[1:0] - 2'h1;
    assign at_end = (lsp_reg != 3'h0) && (pc_reg == lend_mem[ltop]);
    assign fetch_addr = pc_reg;

    // Loop end redirects the fetch in the same cycle, no branch slot
    always @* begin
        pc_next = pc_reg + 24'h1;
        if (at_end && lcnt_mem[ltop] > 32'h1) begin
            pc_next = lstart_mem[ltop];
        end
        if (jump) begin
            pc_next = jump_addr;
        end
        if (!run || fetch_stall) begin
            pc_next = pc_reg;
        end
    end

    always @(posedge clock) begin
        if (rst) begin
            pc_reg <= `PC_RST;
            lsp_reg <= 3'h0;
            for (q = 0; q < `LOOP_DEPTH; q = q + 1) begin
                lend_mem[q] <= 24'h0;
                lstart_mem[q] <= 24'h0;
                lcnt_mem[q] <= 32'h0;
            end
        end else begin
            pc_reg <= pc_next;
            if (run && !fetch_stall && at_end) begin
                if (lcnt_mem[ltop] > 32'h1) begin
                    lcnt_mem[ltop] <= lcnt_mem[ltop] - 32'h1;
                end else begin
                    lsp_reg <= lsp_reg - 3'h1;
                end
            end else if (loop_push && lsp_reg < 3'd4) begin
                lend_mem[lsp_reg[1:0]] <= loop_end_addr;
                lstart_mem[lsp_reg[1:0]] <= pc_next;
                lcnt_mem[lsp_reg[1:0]] <= loop_count;
                lsp_reg <= lsp_reg + 3'h1;
            end
        end
    end

    // ==========================================================
    // Selective cache: 16 sets of two ways, 32 words
    // ==========================================================
    reg [47:0] way0_mem [0:15];
    reg [47:0] way1_mem [0:15];
    reg [19:0] tag0_mem [0:15];
    reg [19:0] tag1_mem [0:15];
    reg [15:0] val0_reg;
    reg [15:0] val1_reg;
    reg [15:0] lru_reg;
    reg miss_reg;
    wire [3:0] set;
    wire hit0;
    wire hit1;
    integer c;

    assign set = pc_reg[3:0];
    assign hit0 = val0_reg[set] && tag0_mem[set] == pc_reg[23:4];
    assign hit1 = val1_reg[set] && tag1_mem[set] == pc_reg[23:4];
    // A colliding miss costs one cycle while memory serves the data
    assign fetch_stall = run && pm_data_access && !hit0 && !hit1 && !miss_reg;

    always @(posedge clock) begin
        if (rst) begin
            val0_reg <= 16'h0;
            val1_reg <= 16'h0;
            lru_reg <= 16'h0;
            miss_reg <= 1'b0;
            instr_out <= 48'h0;
            instr_valid <= 1'b0;
            for (c = 0; c < 16; c = c + 1) begin
                way0_mem[c] <= 48'h0;
                way1_mem[c] <= 48'h0;
                tag0_mem[c] <= 20'h0;
                tag1_mem[c] <= 20'h0;
            end
        end else begin
            miss_reg <= fetch_stall;
            instr_valid <= run && !fetch_stall;
            if (run && pm_data_access && (hit0 || hit1)) begin
                instr_out <= hit0 ? way0_mem[set] : way1_mem[set];
                lru_reg[set] <= hit0;
            end else if (run && !fetch_stall) begin
                instr_out <= pm_instr;
            end
            if (run && miss_reg) begin
                // Fill the least recently used way only after a collision
                if (lru_reg[set]) begin
                    way1_mem[set] <= pm_instr;
                    tag1_mem[set] <= pc_reg[23:4];
                    val1_reg[set] <= 1'b1;
                end else begin
                    way0_mem[set] <= pm_instr;
                    tag0_mem[set] <= pc_reg[23:4];
                    val0_reg[set] <= 1'b1;
                end
                lru_reg[set] <= ~lru_reg[set];
            end
        end
    end

    // ==========================================================
    // Interval timer
    // ==========================================================
    reg [31:0] count_reg;
    reg [31:0] period_reg;

    assign timer_count = count_reg;
    assign timer_zero = timer_en && count_reg == 32'h0;

    // Reload takes the zero cycle itself so the period stays exact
    always @(posedge clock) begin
        if (rst) begin
            count_reg <= 32'h0;
            period_reg <= 32'h0;
            timer_expiry_out <= 1'b0;
        end else begin
            timer_expiry_out <= timer_zero;
            if (timer_period_wr) begin
                period_reg <= timer_wr_data;
            end
            if (timer_count_wr) begin
                count_reg <= timer_wr_data;
            end else if (timer_zero) begin
                count_reg <= period_reg;
            end else if (timer_en) begin
                count_reg <= count_reg - 32'h1;
            end
        end
    end

endmodule

// file: verif/pm_memory_model.sv
/*
 Program memory on the fetch port of the sequencer block.
 Assumes the block wants the word at fetch_addr in the same cycle.
*/
`timescale 1ns/1ps
module pm_memory_model (
    input wire [23:0] fetch_addr,
    output wire [47:0] pm_instr
);
// ==========
// Memory contents
// Each word is derived from its own address, so any fetched word can be checked
assign pm_instr = {fetch_addr, ~fetch_addr};
endmodule

// file: verif/dsp_address_sequencer_timer_assertions.sv
/*
 Port-level checks for the sequencer block.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module dsp_address_sequencer_timer_assertions (
    input wire clock,
    input wire rst,
    input wire [1:0] acc_en,
    input wire [1:0] addr_valid,
    input wire mode_wr,
    input wire [7:0] mode_wr_data,
    input wire [7:0] first_mode_control_reg,
    input wire dreg_lo_alt,
    input wire dreg_hi_alt,
    input wire mr_alt,
    input wire [7:0] arith_exc,
    input wire [7:0] soft_irq,
    input wire [20:0] irq_pending,
    input wire pm_data_access,
    input wire fetch_stall,
    input wire timer_en,
    input wire timer_count_wr,
    input wire [31:0] timer_count,
    input wire timer_expiry_out
);
// ==========
// Properties
default clocking cb @(posedge clock); endclocking
default disable iff (rst);
AST_DUAL_ADDR: assert property (acc_en == 2'h3 |=> addr_valid == 2'h3)
    else $error("both addresses not issued together");
AST_ADDR_CAUSE: assert property (addr_valid[0] |-> $past(acc_en[0]))
    else $error("data address valid without a request");
AST_MODE_TAKE: assert property (mode_wr |=> first_mode_control_reg == $past(mode_wr_data))
    else $error("mode write not taken");
AST_HALF_SEL: assert property (1'b1 |-> dreg_lo_alt == first_mode_control_reg[0] && dreg_hi_alt == first_mode_control_reg[1] && mr_alt == first_mode_control_reg[6])
    else $error("set select outputs differ from mode bits");
AST_RESET_PRIMARY: assert property ($fell(rst) |-> first_mode_control_reg == 8'h00)
    else $error("alternate set active after reset");
AST_SOFT_LATCH: assert property (|soft_irq |=> (irq_pending[20:13] & $past(soft_irq)) == $past(soft_irq))
    else $error("software request not latched");
AST_ARITH_TRAP: assert property (|arith_exc |=> (irq_pending[12:5] & $past(arith_exc)) == $past(arith_exc))
    else $error("exception not latched");
AST_TIMER_DEC: assert property (timer_en && !timer_count_wr && timer_count != 32'h0 |=> timer_count == $past(timer_count) - 32'h1)
    else $error("timer did not count down");
AST_TIMER_EXP: assert property (timer_en && !timer_count_wr && timer_count == 32'h0 |=> timer_expiry_out && irq_pending[4])
    else $error("no expiry at zero");
AST_EXP_ONE: assert property (timer_expiry_out |-> $past(timer_en) && $past(timer_count) == 32'h0)
    else $error("expiry without a zero count");
AST_STALL_CAUSE: assert property (fetch_stall |-> pm_data_access)
    else $error("stall without a collision");
AST_FILL_ONCE: assert property (fetch_stall |=> !fetch_stall)
    else $error("stall repeated after fill");
endmodule
bind dsp_address_sequencer_timer dsp_address_sequencer_timer_assertions chk (.clock(clock),
    .rst(rst), .acc_en(acc_en), .addr_valid(addr_valid), .mode_wr(mode_wr),
    .mode_wr_data(mode_wr_data), .first_mode_control_reg(first_mode_control_reg),
    .dreg_lo_alt(dreg_lo_alt), .dreg_hi_alt(dreg_hi_alt), .mr_alt(mr_alt),
    .arith_exc(arith_exc), .soft_irq(soft_irq), .irq_pending(irq_pending),
    .pm_data_access(pm_data_access), .fetch_stall(fetch_stall), .timer_en(timer_en),
    .timer_count_wr(timer_count_wr), .timer_count(timer_count),
    .timer_expiry_out(timer_expiry_out));

// file: verif/dsp_address_sequencer_timer_test.sv
/*
 Self-checking bench for the sequencer block.
 Assumes the memory model answers fetches in the same cycle.
*/
`timescale 1ns/1ps
`include "dsp_seq_regs.vh"
module dsp_address_sequencer_timer_test;
reg clock = 0;
reg rst = 1;
reg [1:0] dag_wr_en = 0, dag_wr_kind = 0, acc_en = 0, acc_pre = 0;
reg [2:0] dag_wr_idx = 0;
reg [5:0] acc_ptr = 0, acc_mod = 0;
reg [31:0] dag_wr_data = 0, astat_in = 0, loop_count = 3, timer_wr_data = 0;
reg [7:0] mode_wr_data = 0, arith_exc = 0, soft_irq = 0, mv [0:5];
reg [3:0] ext_irq = 0;
reg [4:0] irq_ack_idx = 0;
reg [23:0] jump_addr = 0, loop_end_addr = 0, a;
reg mode_wr = 0, irq_ack = 0, irq_ret = 0, run = 0, jump = 0, loop_push = 0;
reg pm_data_access = 0, timer_en = 0, timer_count_wr = 0, timer_period_wr = 0;
reg [31:0] b [0:1], l [0:1], p [0:1], m [0:1], e [0:1], sv [0:5];
reg [2:0] ix [0:1], jx [0:1];
wire [31:0] data_space_addr_gen, astat_restore, timer_count;
wire [23:0] program_space_addr_gen, fetch_addr;
wire [1:0] addr_valid;
wire [7:0] first_mode_control_reg;
wire [20:0] irq_pending;
wire [47:0] pm_instr, instr_out;
wire dreg_lo_alt, dreg_hi_alt, mr_alt, astat_restore_valid, irq_request, stack_overflow;
wire instr_valid, fetch_stall, timer_expiry_out;
integer errors = 0, samples_checked = 0, n, k, g;
// ==========
// Design, memory and clock
dsp_address_sequencer_timer dut (.*);
pm_memory_model mem (.fetch_addr(fetch_addr), .pm_instr(pm_instr));
always #2.5 clock = ~clock;
// ==========
// Helpers
task check(input [63:0] seen, input [63:0] exp);
begin
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
        errors = errors + 1;
        $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
end
endtask
task test_done;
begin
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
        $display("TB: PASS");
    end else begin
        $display("TB: FAIL");
    end
    $finish;
end
endtask
// A wait that ran out of cycles ends the run at once
task limit(input integer c);
begin
    if (c >= 40) begin
        errors = errors + 1;
        test_done;
    end
end
endtask
// Expected pointer after modify: one wrap each way, none for length zero
function [31:0] wrap(input [31:0] s, input [31:0] bb, input [31:0] ll);
begin
    if (ll != 0 && s >= bb + ll)
        wrap = s - ll;
    else if (ll != 0 && s < bb)
        wrap = s + ll;
    else
        wrap = s;
end
endfunction
task gw(input [1:0] gm, input [1:0] kd, input [2:0] i, input [31:0] d);
begin
    @(posedge clock);
    dag_wr_en <= gm;
    dag_wr_kind <= kd;
    dag_wr_idx <= i;
    dag_wr_data <= d;
    @(posedge clock);
    dag_wr_en <= 0;
end
endtask
task setp(input [1:0] gm, input [2:0] i, input [2:0] j, input [31:0] pv, mq, bv, lv);
begin
    gw(gm, `KIND_BASE, i, bv);
    gw(gm, `KIND_LEN, i, lv);
    gw(gm, `KIND_MOD, j, mq);
    gw(gm, `KIND_PTR, i, pv);
end
endtask
// Both generators are always asked together, so every access is a dual one
task ac(input [5:0] pi, input [5:0] mi, input [1:0] pre);
begin
    @(posedge clock);
    acc_en <= 2'h3;
    acc_ptr <= pi;
    acc_mod <= mi;
    acc_pre <= pre;
    @(posedge clock);
    acc_en <= 0;
    #1;
end
endtask
task md(input [7:0] v);
begin
    @(posedge clock);
    mode_wr <= 1;
    mode_wr_data <= v;
    @(posedge clock);
    mode_wr <= 0;
end
endtask
task irq(input ak, input rt, input [4:0] idx);
begin
    @(posedge clock);
    irq_ack <= ak;
    irq_ret <= rt;
    irq_ack_idx <= idx;
    @(posedge clock);
    irq_ack <= 0;
    irq_ret <= 0;
    #1;
end
endtask
task tw(input [31:0] d);
begin
    @(posedge clock);
    timer_period_wr <= 1;
    timer_wr_data <= d;
    @(posedge clock);
    timer_period_wr <= 0;
end
endtask
task wexp;
begin
    n = 0;
    do begin
        @(posedge clock);
        #1;
        n = n + 1;
    end while (timer_expiry_out !== 1'b1 && n < 40);
    limit(n);
end
endtask
task jump_to(input [23:0] ad, input pda, input lp);
begin
    @(posedge clock);
    jump <= 1;
    jump_addr <= ad;
    run <= 1;
    pm_data_access <= 0;
    @(posedge clock);
    jump <= 0;
    pm_data_access <= pda;
    loop_push <= lp;
    #1;
end
endtask
task idle;
begin
    @(posedge clock);
    pm_data_access <= 0;
    run <= 0;
end
endtask
// ==========
// Main sequence
initial begin
    k = $urandom(32'h7ace);
    repeat (16) @(posedge clock);
    rst <= 0;
    #1;
    check({first_mode_control_reg, dreg_lo_alt, dreg_hi_alt, mr_alt}, 0);
    // Random buffers on both generators, lengths zero first, then wraps both ways
    for (n = 0; n < 8; n = n + 1) begin
        for (g = 0; g < 2; g = g + 1) begin
            ix[g] = $urandom;
            jx[g] = $urandom;
            b[g] = ($urandom & 32'hfff000) | 32'h100000;
            l[g] = (n == 0) ? 0 : 1 + $urandom % 64;
            p[g] = b[g] + $urandom % (l[g] + 1);
            m[g] = n[0] ? -(1 + $urandom % 64) : $urandom % 64;
            setp(g ? 2'h2 : 2'h1, ix[g], jx[g], p[g], m[g], b[g], l[g]);
        end
        k = $urandom;
        ac({ix[1], ix[0]}, {jx[1], jx[0]}, k[1:0]);
        for (g = 0; g < 2; g = g + 1) begin
            e[g] = wrap(p[g] + m[g], b[g], l[g]);
            if (k[g])
                p[g] = e[g];
        end
        check(data_space_addr_gen, p[0]);
        check(program_space_addr_gen, p[1][23:0]);
        check(addr_valid, 2'h3);
        ac({ix[1], ix[0]}, {jx[1], jx[0]}, 2'h0);
        check(data_space_addr_gen, e[0]);
        check(program_space_addr_gen, e[1][23:0]);
    end
    // Alternate low group on one generator, high group left primary
    setp(2'h1, 2, 0, 32'h40, 0, 0, 0);
    setp(2'h1, 5, 4, 32'h50, 0, 0, 0);
    md(8'h04);
    setp(2'h1, 2, 0, 32'h60, 0, 0, 0);
    ac(6'h02, 6'h00, 2'h0);
    check(data_space_addr_gen, 32'h60);
    ac(6'h05, 6'h04, 2'h0);
    check(data_space_addr_gen, 32'h50);
    md(8'h00);
    ac(6'h02, 6'h00, 2'h0);
    check(data_space_addr_gen, 32'h40);
    // Latched sources, then acknowledge the arithmetic and software ones
    k = $urandom;
    @(posedge clock);
    soft_irq <= k[7:0];
    arith_exc <= k[15:8];
    ext_irq <= 4'h2;
    @(posedge clock);
    soft_irq <= 0;
    arith_exc <= 0;
    #1;
    check({irq_request, irq_pending[20:5]}, {1'b0, k[7:0], k[15:8]});
    for (n = 0; n < 40 && irq_pending[1] !== 1'b1; n = n + 1)
        @(posedge clock);
    limit(n);
    ext_irq <= 0;
    for (g = 5; g < 21; g = g + 1)
        irq(1, 0, g);
    // Six pushes: the sixth finds the stack full
    for (g = 0; g < 6; g = g + 1) begin
        mv[g] = $urandom;
        sv[g] = $urandom;
        md(mv[g]);
        astat_in <= sv[g];
        irq(1, 0, g % 5);
        check(stack_overflow, g == 5);
    end
    check(irq_pending, 0);
    for (g = 4; g >= 0; g = g - 1) begin
        irq(0, 1, 0);
        check({astat_restore_valid, astat_restore, first_mode_control_reg}, {1'b1, sv[g], mv[g]});
    end
    // Timer periods of random length, measured expiry to expiry
    @(posedge clock);
    timer_en <= 1;
    for (g = 0; g < 3; g = g + 1) begin
        k = 2 + $urandom % 6;
        tw(k);
        wexp;
        check({irq_pending[4], timer_count}, {1'b1, k});
        @(posedge clock);
        #1;
        check({timer_expiry_out, timer_count}, k - 1);
        wexp;
        check(n, k);
    end
    @(posedge clock);
    timer_en <= 0;
    // Colliding miss fills, plain fetch does not, colliding hit does not stall
    a = $urandom;
    a[3:0] = 4'h3;
    jump_to(a, 1, 0);
    check(fetch_stall, 1);
    @(posedge clock);
    idle;
    jump_to(a + 6, 0, 0);
    idle;
    jump_to(a + 6, 1, 0);
    check(fetch_stall, 1);
    @(posedge clock);
    idle;
    jump_to(a, 1, 0);
    check(fetch_stall, 0);
    idle;
    #1;
    check({instr_valid, instr_out}, {1'b1, a, ~a});
    // Three passes over a two-word loop, then fall through
    @(posedge clock);
    loop_end_addr <= a + 2;
    jump_to(a, 0, 1);
    for (k = 0; k < 7; k = k + 1) begin
        @(posedge clock);
        loop_push <= 0;
        #1;
        check(fetch_addr, a + (k == 6 ? 3 : 1 + k % 2));
    end
    idle;
    test_done;
end
endmodule
